// File: asr_pkg.sv
package asr_pkg;

  localparam int unsigned ASR_ADDR_W = 19;
  localparam int unsigned ASR_DATA_W = 8;
  localparam int unsigned ASR_CLK_PERIOD_NS = 10;

  // Least times round up to whole cycles
  localparam int unsigned ASR_CYCLE_TIME_NS              = 70;
  localparam int unsigned ASR_SELECT_TO_WRITE_END_NS     = 60;
  localparam int unsigned ASR_ADDRESS_TO_WRITE_END_NS    = 60;
  localparam int unsigned ASR_ADDRESS_TO_WRITE_START_NS  = 0;
  localparam int unsigned ASR_WRITE_PULSE_WIDTH_NS       = 50;
  localparam int unsigned ASR_DATA_SETUP_WRITE_NS        = 30;
  localparam int unsigned ASR_DATA_HOLD_WRITE_NS         = 0;
  localparam int unsigned ASR_WRITE_TO_OUTPUT_OFF_NS     = 25;
  localparam int unsigned ASR_ADDRESS_ACCESS_TIME_NS     = 70;
  localparam int unsigned ASR_SELECT_ACCESS_TIME_NS      = 70;
  localparam int unsigned ASR_GATE_ACCESS_TIME_NS        = 35;
  localparam int unsigned ASR_OUTPUT_OFF_NS              = 25;

  function automatic int unsigned asr_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns + ASR_CLK_PERIOD_NS - 1) / ASR_CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned ASR_CNT_W = 4;

  // Low phase of the write strobe: covers pulse width, select and address to write end
  localparam logic [ASR_CNT_W-1:0] ASR_WR_LOW_CYC = ASR_CNT_W'(asr_cycles(ASR_SELECT_TO_WRITE_END_NS));
  // Read waits for the slowest of address, select and gate access
  localparam logic [ASR_CNT_W-1:0] ASR_RD_CYC     = ASR_CNT_W'(asr_cycles(ASR_SELECT_ACCESS_TIME_NS));
  // Bus turnaround after a read before the controller may drive data
  localparam logic [ASR_CNT_W-1:0] ASR_TURN_CYC   = ASR_CNT_W'(asr_cycles(ASR_OUTPUT_OFF_NS));
  // Recovery so that consecutive cycles are at least one cycle time apart
  localparam logic [ASR_CNT_W-1:0] ASR_GAP_CYC    =
    ASR_CNT_W'(asr_cycles(ASR_CYCLE_TIME_NS - ASR_SELECT_TO_WRITE_END_NS));
  localparam logic [ASR_CNT_W-1:0] ASR_CNT_ONE    = 4'h1;
  localparam logic [ASR_CNT_W-1:0] ASR_CNT_ZERO   = 4'h0;

  typedef enum logic [2:0] {
    ASR_IDLE  = 3'b000,
    ASR_WSET  = 3'b001,
    ASR_WLOW  = 3'b010,
    ASR_READ  = 3'b011,
    ASR_TURN  = 3'b100,
    ASR_GAP   = 3'b101
  } asr_state_t;

  typedef struct packed {
    logic                  write;
    logic [ASR_ADDR_W-1:0] addr;
    logic [ASR_DATA_W-1:0] wdata;
  } asr_req_t;

  typedef struct packed {
    logic                  select_n;
    logic                  write_n;
    logic                  gate_n;
    logic [ASR_ADDR_W-1:0] addr;
    logic [ASR_DATA_W-1:0] dq_out;
    logic                  dq_oe;
  } asr_pins_t;

endpackage

// File: asr_timer.sv
`timescale 1ns/1ps
`default_nettype none
module asr_timer
  import asr_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 load_i,
  input  wire logic [ASR_CNT_W-1:0] value_i,
  output logic                      done_o
);

  typedef struct packed {
    logic [ASR_CNT_W-1:0] cnt;
  } asr_tmr_state_t;

  asr_tmr_state_t st;
  asr_tmr_state_t next_st;

  always_comb begin
    next_st = st;
    if (load_i) begin
      next_st.cnt = value_i;
    end else if (st.cnt != ASR_CNT_ZERO) begin
      next_st.cnt = st.cnt - ASR_CNT_ONE;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Done in the cycle whose edge completes the count. It must not look at load_i:
  // the owner reloads inside the branch that done_o selects, which would close a loop
  assign done_o = (st.cnt == ASR_CNT_ONE);

endmodule
`default_nettype wire

// File: asr_host.sv
`timescale 1ns/1ps
`default_nettype none
module asr_host
  import asr_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  req_valid_i,
  output logic                       req_ready_o,
  input  wire asr_req_t              req_i,
  output logic                       rsp_valid_o,
  output logic [ASR_DATA_W-1:0]      rsp_data_o,
  output logic                       busy_o,
  output logic                       mem_select_n_o,
  output logic                       mem_write_n_o,
  output logic                       mem_gate_n_o,
  output logic [ASR_ADDR_W-1:0]      mem_addr_o,
  output logic [ASR_DATA_W-1:0]      mem_dq_o,
  output logic                       mem_dq_oe_o,
  input  wire logic [ASR_DATA_W-1:0] mem_dq_i
);

  typedef struct packed {
    asr_state_t            fsm;
    asr_pins_t             pins;
    logic                  rsp_valid;
    logic [ASR_DATA_W-1:0] rsp_data;
  } asr_host_state_t;

  asr_host_state_t st;
  asr_host_state_t next_st;

  logic                 tmr_load;
  logic [ASR_CNT_W-1:0] tmr_value;
  logic                 tmr_done;

  asr_timer u_timer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .load_i  (tmr_load),
    .value_i (tmr_value),
    .done_o  (tmr_done)
  );

  localparam asr_pins_t ASR_PINS_IDLE = '{
    select_n: 1'b1, write_n: 1'b1, gate_n: 1'b1,
    addr: '0, dq_out: '0, dq_oe: 1'b0
  };

  assign req_ready_o = (st.fsm == ASR_IDLE);

  always_comb begin
    next_st           = st;
    next_st.rsp_valid = 1'b0;
    tmr_load          = 1'b0;
    tmr_value         = ASR_CNT_ZERO;
    case (st.fsm)
      ASR_IDLE: begin
        if (req_valid_i) begin
          // Address and select together: zero lead to write start, valid at select fall
          next_st.pins.addr     = req_i.addr;
          next_st.pins.select_n = 1'b0;
          tmr_load              = 1'b1;
          if (req_i.write) begin
            // Gate stays high so no output turn-off time stretches the cycle
            next_st.pins.gate_n  = 1'b1;
            next_st.pins.write_n = 1'b0;
            next_st.pins.dq_out  = req_i.wdata;
            next_st.pins.dq_oe   = 1'b1;
            tmr_value            = ASR_WR_LOW_CYC;
            next_st.fsm          = ASR_WLOW;
          end else begin
            next_st.pins.write_n = 1'b1;
            next_st.pins.gate_n  = 1'b0;
            next_st.pins.dq_oe   = 1'b0;
            tmr_value            = ASR_RD_CYC;
            next_st.fsm          = ASR_READ;
          end
        end
      end
      ASR_WLOW: begin
        if (tmr_done) begin
          // Strobe rises alone, ending the write while select still low
          next_st.pins.write_n = 1'b1;
          next_st.fsm          = ASR_WSET;
        end
      end
      ASR_WSET: begin
        // Zero hold: data and select released one edge after the strobe; address held until the next request
        next_st.pins.select_n = 1'b1;
        next_st.pins.dq_oe    = 1'b0;
        tmr_load              = 1'b1;
        tmr_value             = ASR_GAP_CYC;
        next_st.fsm           = ASR_GAP;
      end
      ASR_READ: begin
        if (tmr_done) begin
          next_st.rsp_valid     = 1'b1;
          next_st.rsp_data      = mem_dq_i;
          next_st.pins.gate_n   = 1'b1;
          next_st.pins.select_n = 1'b1;
          tmr_load              = 1'b1;
          tmr_value             = ASR_TURN_CYC;
          next_st.fsm           = ASR_TURN;
        end
      end
      ASR_TURN: begin
        // Bus stays undriven until the memory's outputs are off
        if (tmr_done) begin
          next_st.fsm = ASR_IDLE;
        end
      end
      ASR_GAP: begin
        if (tmr_done) begin
          next_st.fsm = ASR_IDLE;
        end
      end
      default: begin
        next_st.fsm  = ASR_IDLE;
        next_st.pins = ASR_PINS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st.fsm       <= ASR_IDLE;
      st.pins      <= ASR_PINS_IDLE;
      st.rsp_valid <= 1'b0;
      st.rsp_data  <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rsp_valid_o    = st.rsp_valid;
  assign rsp_data_o     = st.rsp_data;
  assign busy_o         = (st.fsm != ASR_IDLE);
  assign mem_select_n_o = st.pins.select_n;
  assign mem_write_n_o  = st.pins.write_n;
  assign mem_gate_n_o   = st.pins.gate_n;
  assign mem_addr_o     = st.pins.addr;
  assign mem_dq_o       = st.pins.dq_out;
  assign mem_dq_oe_o    = st.pins.dq_oe;

endmodule
`default_nettype wire

// File: asr_host_properties.sv
`timescale 1ns/1ps
`default_nettype none
module asr_host_properties
  import asr_pkg::*;
(
  input wire logic                  clk_i,
  input wire logic                  rst_n_i,
  input wire logic                  rsp_valid_o,
  input wire logic                  mem_select_n_o,
  input wire logic                  mem_write_n_o,
  input wire logic                  mem_gate_n_o,
  input wire logic [ASR_ADDR_W-1:0] mem_addr_o,
  input wire logic [ASR_DATA_W-1:0] mem_dq_o,
  input wire logic                  mem_dq_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_wr_in; !mem_write_n_o |-> !mem_select_n_o; endproperty
  a_wr_in: assert property (p_wr_in) else $error("strobe outside select");
  property p_wr_end; $rose(mem_write_n_o) |-> !mem_select_n_o ##1 mem_select_n_o; endproperty
  a_wr_end: assert property (p_wr_end) else $error("write end order");
  property p_wr_len; $fell(mem_write_n_o) |-> !mem_write_n_o[*6] ##1 mem_write_n_o; endproperty
  a_wr_len: assert property (p_wr_len) else $error("strobe width");
  property p_sel_len; $fell(mem_write_n_o) |-> !mem_select_n_o[*7] ##1 mem_select_n_o; endproperty
  a_sel_len: assert property (p_sel_len) else $error("select width");
  property p_addr; !mem_select_n_o && !$fell(mem_select_n_o) |-> $stable(mem_addr_o); endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_data; !mem_write_n_o && !$fell(mem_write_n_o) |-> mem_dq_oe_o && $stable(mem_dq_o); endproperty
  a_data: assert property (p_data) else $error("write data moved");
  property p_gate_wr; !mem_write_n_o |-> mem_gate_n_o; endproperty
  a_gate_wr: assert property (p_gate_wr) else $error("gate low in write");
  property p_oe; mem_dq_oe_o |-> !mem_select_n_o && mem_gate_n_o; endproperty
  a_oe: assert property (p_oe) else $error("bus contention");
  property p_rd; $fell(mem_gate_n_o) |-> (!mem_gate_n_o && mem_write_n_o && !mem_dq_oe_o)[*7] ##1 mem_gate_n_o;
  endproperty
  a_rd: assert property (p_rd) else $error("read shape");
  property p_rsp; $rose(mem_gate_n_o) |-> ##[0:1] rsp_valid_o; endproperty
  a_rsp: assert property (p_rsp) else $error("no read answer");
  property p_gap; $rose(mem_select_n_o) |-> mem_select_n_o[*2]; endproperty
  a_gap: assert property (p_gap) else $error("cycles too close");
  c_wr: cover property ($fell(mem_write_n_o));
  c_rd: cover property ($rose(rsp_valid_o));
  c_b2b: cover property ($rose(mem_select_n_o) ##2 $fell(mem_select_n_o));
endmodule
bind asr_host asr_host_properties u_props (.*);
`default_nettype wire

// File: asr_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module asr_mem_model
  import asr_pkg::*;
#(
  parameter int unsigned ACC_NS = 68
)
(
  input  wire logic                  sel_n_i,
  input  wire logic                  we_n_i,
  input  wire logic                  oe_n_i,
  input  wire logic [ASR_ADDR_W-1:0] addr_i,
  input  wire logic [ASR_DATA_W-1:0] bus_i,
  output logic      [ASR_DATA_W-1:0] dq_o
);
  logic [ASR_DATA_W-1:0] mem [16];
  logic                  on;
  assign on = !sel_n_i && !oe_n_i && we_n_i;
  initial begin
    dq_o = 8'h5A;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // First strobe to rise while the other is low ends the write
  always @(posedge sel_n_i or posedge we_n_i) begin
    if (sel_n_i ^ we_n_i) mem[addr_i[3:0]] = bus_i;
  end
  // Access kept just under the limit: landing on the sampling edge would race
  always @(addr_i or on) begin
    dq_o <= #10 ~dq_o;
    dq_o <= #(ACC_NS) on ? mem[addr_i[3:0]] : ~dq_o;
  end
endmodule
`default_nettype wire

// File: asr_host_test.sv
`timescale 1ns/1ps
`default_nettype none
module asr_host_test;
  import asr_pkg::*;
  logic                  clk_i = 1'b0;
  logic                  rst_n_i = 1'b0;
  logic                  req_valid_i = 1'b0;
  asr_req_t              req_i = '0;
  logic                  rdy, rv, busy, sel_n, we_n, oe_n, oe;
  logic [ASR_DATA_W-1:0] rdata, hdq, mdq, bus, d;
  logic [ASR_ADDR_W-1:0] addr;
  int                    failures = 0;
  int                    samples_checked = 0;
  assign bus = oe ? hdq : mdq;
  initial forever #5 clk_i = ~clk_i;
  asr_host DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_ready_o(rdy), .req_i(req_i),
    .rsp_valid_o(rv), .rsp_data_o(rdata), .busy_o(busy), .mem_select_n_o(sel_n), .mem_write_n_o(we_n),
    .mem_gate_n_o(oe_n), .mem_addr_o(addr), .mem_dq_o(hdq), .mem_dq_oe_o(oe), .mem_dq_i(bus));
  asr_mem_model u_mem (.sel_n_i(sel_n), .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(addr), .bus_i(bus), .dq_o(mdq));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (exp !== got) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Ready is read a step after an edge, where it has settled; the request then
  // stands over the taking edge and is dropped one step after it
  task automatic send(input logic w, input logic [ASR_ADDR_W-1:0] a, input logic [ASR_DATA_W-1:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    #1 req_valid_i = 1'b1;
    req_i = '{write: w, addr: a, wdata: v};
    while (rdy !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      #1 n++;
    end
    chk("req_ready", 1, rdy);
    @(posedge clk_i);
    #1 req_valid_i = 1'b0;
  endtask
  task automatic rd(input logic [ASR_ADDR_W-1:0] a, output logic [ASR_DATA_W-1:0] v);
    int n;
    send(1'b0, a, 8'h00);
    n = 0;
    while (rv !== 1'b1 && n < 20) begin @(posedge clk_i); #1; n++; end
    chk("rsp_valid", 1, rv);
    chk("read latency", ASR_RD_CYC, n);
    v = rdata;
    @(posedge clk_i);
    #1 chk("rsp_valid pulse", 0, rv);
  endtask
  task automatic t_wr_rd;
    logic [ASR_ADDR_W-1:0] at [3];
    logic [ASR_DATA_W-1:0] dt [3];
    at = '{19'h7FFFF, 19'h00005, 19'h4000A};
    dt = '{8'hA5, 8'h3C, 8'hFF};
    for (int i = 0; i < 3; i++) send(1'b1, at[i], dt[i]);
    for (int i = 0; i < 3; i++) begin
      rd(at[i], d);
      chk("read data", dt[i], d);
    end
    rd(19'h00003, d);
    chk("unwritten", 8'h00, d);
    $display("test wr_rd done");
  endtask
  task automatic t_b2b;
    send(1'b1, 19'h00005, 8'h81);
    chk("busy", 1, busy);
    rd(19'h00005, d);
    chk("overwrite", 8'h81, d);
    $display("test b2b done");
  endtask
  task automatic t_reset_mid;
    send(1'b1, 19'h00006, 8'h77);
    repeat (3) @(posedge clk_i);
    #1 rst_n_i = 1'b0;
    #1 chk("pins in reset", 5'h1D, {sel_n, we_n, oe_n, oe, rdy});
    @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    rd(19'h7FFFF, d);
    chk("after reset", 8'hA5, d);
    $display("test reset_mid done");
  endtask
  initial begin
    #20000;
    failures++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    #1 chk("reset pins", 5'h1D, {sel_n, we_n, oe_n, oe, rdy});
    rst_n_i = 1'b1;
    t_wr_rd();
    t_b2b();
    t_reset_mid();
    end_sim();
  end
endmodule
`default_nettype wire
